// ### rtl/arc_ctrl.sv
// Purpose: Result byte coherency, completion flag and interrupt for the converter.
// Assumes: Converter core outside; conv_done is a one-cycle pulse in the bus domain.
// Assumes: Software turns the converter off before it selects a new channel.
// Notes: Unmapped reads return zero; APB answers with no wait state.
// Notes: Read data is combinational, so the high byte and the low snapshot
//        both come from the same pre-edge result word.
//
// The implementer's own choices: register access over APB and the register offsets.
`timescale 1ns/1ps
module arc_ctrl
  import arc_pkg::*;
(
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rstn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // Converter core
  input  wire logic        conv_done,
  input  wire logic [11:0] conv_data,
  output logic [4:0]       conv_channel,
  output logic             conv_continuous,
  output logic [1:0]       conv_mode,
  output logic             conv_async_clk,
  output logic             conv_start,
  // Interrupt request
  output logic             irq
);

  // Control and config state
  // The result word updates on every completion; only the low byte view
  // is ever held, so the high byte always tracks the newest conversion.
  logic        conversion_complete_flag;  // Sticky completion flag
  logic        int_enable;                // Completion interrupt enable
  logic [11:0] conversion_result_reg;     // Latest result
  logic [7:0]  low_hold;                  // Frozen low byte
  logic        low_frozen;                // Low byte is held
  logic        irq_q;                     // Registered interrupt

  // Access decode
  // Every action takes effect at the access edge, where pready is high;
  // setup cycles never change state.
  wire acc        = psel & penable;
  wire wr_ctrl    = acc & pwrite & (paddr == ARC_OFS_CTRL);
  wire wr_cfg     = acc & pwrite & (paddr == ARC_OFS_CFG);
  wire rd_hi      = acc & ~pwrite & (paddr == ARC_OFS_RES_HI);
  wire rd_lo      = acc & ~pwrite & (paddr == ARC_OFS_RES_LO);
  wire wide_mode  = (conv_mode != ARC_MODE_8);

  // Result alignment per mode
  // Raw data is left-justified, so narrower modes drop low-order bits
  function automatic logic [15:0] arc_align(input logic [1:0] m, input logic [11:0] d);
    if (m == ARC_MODE_8)
      arc_align = {8'h00, d[11:4]};
    else if (m == ARC_MODE_10)
      arc_align = {6'h00, d[11:2]};
    else
      arc_align = {4'h0, d};
  endfunction : arc_align

  // Live view versus held low byte
  wire [15:0] live_res = arc_align(conv_mode, conversion_result_reg);
  wire [7:0]  low_view = low_frozen ? low_hold : live_res[7:0];

  // Read mux
  // Unmapped offsets fall through to zero rather than raising an error
  wire [31:0] ctrl_word = {24'h000000, conversion_complete_flag, int_enable,
                           conv_continuous, conv_channel};
  wire [31:0] cfg_word  = {29'h00000000, conv_async_clk, conv_mode};
  wire [31:0] next_prdata =
      (paddr == ARC_OFS_CTRL)   ? ctrl_word :
      (paddr == ARC_OFS_RES_HI) ? {24'h000000, live_res[15:8]} :
      (paddr == ARC_OFS_RES_LO) ? {24'h000000, low_view} :
      (paddr == ARC_OFS_CFG)    ? cfg_word : 32'h00000000;

  // Zero wait states: every access completes in its first access cycle
  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  assign prdata  = next_prdata;

  // Control register; async clock select is a config bit
  // Keeping the clock select out of control means a channel change cannot move it
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      conv_channel    <= ARC_CH_OFF_RST;
      conv_continuous <= 1'b0;
      int_enable      <= 1'b0;
      conv_mode       <= ARC_MODE_RST;
      conv_async_clk  <= 1'b0;
      conv_start      <= 1'b0;
    end else begin
      // Start pulse only when a real channel is chosen; all-ones means off
      conv_start <= wr_ctrl & (pwdata[ARC_CTRL_CH_LSB +: ARC_CTRL_CH_W] != ARC_CH_OFF_RST);
      if (wr_ctrl) begin
        conv_channel    <= pwdata[ARC_CTRL_CH_LSB +: ARC_CTRL_CH_W];
        conv_continuous <= pwdata[ARC_CTRL_CONT_BIT];
        int_enable      <= pwdata[ARC_CTRL_IE_BIT];
      end
      if (wr_cfg) begin
        conv_mode      <= pwdata[ARC_CFG_MODE_LSB +: 2];
        conv_async_clk <= pwdata[ARC_CFG_ASYNC_BIT];
      end
    end
  end

  // Completion flag: a completion in the write cycle keeps it set
  // Set beats clear so a conversion that lands during the write is never
  // lost; software then sees the flag and the matching result together
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn)
      conversion_complete_flag <= 1'b0;
    else if (conv_done)
      conversion_complete_flag <= 1'b1;
    else if (wr_ctrl)
      conversion_complete_flag <= 1'b0;
  end

  // Result capture always updates the full word
  // No hold here: holding the whole word would make the high byte stale
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn)
      conversion_result_reg <= 12'h000;
    else if (conv_done)
      conversion_result_reg <= conv_data;
  end

  // Low byte freeze; snapshot taken from pre-edge result so a same-cycle
  // completion cannot leak a newer low byte
  // A second high read while held keeps the first snapshot, so a completion
  // between high reads pairs a newer high byte with the older low byte; eight-bit mode drops the hold
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      low_frozen <= 1'b0;
      low_hold   <= 8'h00;
    end else if (rd_hi && wide_mode) begin
      low_frozen <= 1'b1;
      if (!low_frozen)
        low_hold <= live_res[7:0];
    end else if (rd_lo || !wide_mode) begin
      low_frozen <= 1'b0;
    end
  end

  // Interrupt level from flag and enable, registered
  // Registering costs one cycle of latency but keeps irq glitch-free
  // while the flag and the enable settle on the same edge
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn)
      irq_q <= 1'b0;
    else
      irq_q <= conversion_complete_flag & int_enable;
  end
  assign irq = irq_q;

  // Assertions
  // Coherency checks on the result byte pair, plus the clock select write
  AST_FREEZE: assert property (@(posedge clock) disable iff (!rstn)
    (rd_hi && wide_mode && !low_frozen) |=> (low_frozen && low_hold == $past(live_res[7:0])))
    else $error("low byte not frozen on high read");
  AST_HOLD: assert property (@(posedge clock) disable iff (!rstn)
    (low_frozen && !rd_lo && wide_mode) |=> (low_frozen && $stable(low_hold)))
    else $error("frozen low byte changed before low read");
  AST_SAMECYC: assert property (@(posedge clock) disable iff (!rstn)
    (rd_hi && conv_done && wide_mode && !low_frozen) |=>
      (low_view == $past(live_res[7:0])))
    else $error("newer low byte leaked on same-cycle completion");
  AST_EIGHT: assert property (@(posedge clock) disable iff (!rstn)
    (conv_mode == ARC_MODE_8) |=> (!low_frozen || conv_mode != ARC_MODE_8))
    else $error("freeze active in eight-bit mode");
  AST_ASYNC: assert property (@(posedge clock) disable iff (!rstn)
    wr_cfg |=> (conv_async_clk == $past(pwdata[ARC_CFG_ASYNC_BIT])))
    else $error("clock select not written");

  // Flag, capture and interrupt checks
  AST_CLEAR: assert property (@(posedge clock) disable iff (!rstn)
    (wr_ctrl && !conv_done) |=> !conversion_complete_flag)
    else $error("control write did not clear flag");
  AST_KEEP: assert property (@(posedge clock) disable iff (!rstn)
    (wr_ctrl && conv_done) |=> (conversion_complete_flag &&
      conversion_result_reg == $past(conv_data)))
    else $error("completion during write lost");
  AST_IRQ: assert property (@(posedge clock) disable iff (!rstn)
    (wr_ctrl && conv_done && pwdata[ARC_CTRL_IE_BIT]) |=> ##1 irq)
    else $error("interrupt not raised after write");
  AST_IRQ_LVL: assert property (@(posedge clock) disable iff (!rstn)
    1'b1 |=> (irq == $past(conversion_complete_flag && int_enable)))
    else $error("interrupt does not follow flag and enable");
  AST_SET: assert property (@(posedge clock) disable iff (!rstn)
    conv_done |=> (conversion_complete_flag && conversion_result_reg == $past(conv_data)))
    else $error("completion not captured");

  // Read view checks, plus the clock select hold on control writes
  AST_THAW: assert property (@(posedge clock) disable iff (!rstn)
    (low_frozen && rd_lo) |=> !low_frozen)
    else $error("low byte still held after low read");
  AST_LO_VIEW: assert property (@(posedge clock) disable iff (!rstn)
    (rd_lo && low_frozen) |-> (prdata[7:0] == low_hold))
    else $error("low read does not return the held byte");
  AST_EIGHT_HI: assert property (@(posedge clock) disable iff (!rstn)
    (rd_hi && !wide_mode) |-> (prdata[7:0] == 8'h00))
    else $error("high byte not zero in eight-bit mode");
  AST_EIGHT_LO: assert property (@(posedge clock) disable iff (!rstn)
    (rd_lo && !wide_mode) |-> (prdata[7:0] == live_res[7:0]))
    else $error("eight-bit read does not show the live result");
  AST_CLK_SEL: assert property (@(posedge clock) disable iff (!rstn)
    wr_ctrl |=> $stable(conv_async_clk))
    else $error("control write moved the clock select");

  // Covers
  // The rare same-cycle cases must be reached, not only be legal
  COV_SAMECYC: cover property (@(posedge clock) disable iff (!rstn)
    rd_hi && conv_done && wide_mode);
  COV_PAIR: cover property (@(posedge clock) disable iff (!rstn)
    (rd_hi && wide_mode) ##1 rd_lo);
  COV_RACE: cover property (@(posedge clock) disable iff (!rstn)
    wr_ctrl && conv_done);
  COV_IRQ: cover property (@(posedge clock) disable iff (!rstn) $rose(irq));
  COV_EIGHT: cover property (@(posedge clock) disable iff (!rstn)
    rd_hi && !wide_mode);

endmodule : arc_ctrl

// ### rtl/arc_pkg.sv
// Purpose: Constants for the converter result coherency and completion control.
// Assumes: APB with 32-bit data, one aligned word per register.
// Notes: Offsets are byte addresses.
package arc_pkg;
  // Register byte offsets
  localparam logic [7:0] ARC_OFS_CTRL   = 8'h00;
  localparam logic [7:0] ARC_OFS_RES_HI = 8'h04;
  localparam logic [7:0] ARC_OFS_RES_LO = 8'h08;
  localparam logic [7:0] ARC_OFS_CFG    = 8'h0C;
  // Control field positions
  localparam int ARC_CTRL_FLAG_BIT = 7;
  localparam int ARC_CTRL_IE_BIT   = 6;
  localparam int ARC_CTRL_CONT_BIT = 5;
  localparam int ARC_CTRL_CH_LSB   = 0;
  localparam int ARC_CTRL_CH_W     = 5;
  // Config field positions
  localparam int ARC_CFG_MODE_LSB  = 0;
  localparam int ARC_CFG_ASYNC_BIT = 2;
  // Reset values
  localparam logic [4:0] ARC_CH_OFF_RST = 5'h1F;
  localparam logic [1:0] ARC_MODE_RST   = 2'h0;
  // Result width modes
  typedef enum logic [1:0] {
    ARC_MODE_8  = 2'h0,
    ARC_MODE_12 = 2'h1,
    ARC_MODE_10 = 2'h2
  } arc_mode_type;
endpackage : arc_pkg

// ### sim/testbench.sv
// Purpose: Self-checking bench for result coherency and the completion flag.
// Assumes: Zero-wait APB slave; conv_done is a one-cycle pulse.
// Notes: Table rows first, then same-cycle cases, with a mid-run reset last.
`timescale 1ns/1ps
module testbench;
  import arc_pkg::*;
  // One table row: mode, result, expected bytes
  typedef struct packed {
    logic [1:0]  mode;
    logic [11:0] data;
    logic [7:0]  hi;
    logic [7:0]  lo;
  } arc_row_type;
  logic        clock, rstn, psel, penable, pwrite, pready, pslverr;
  logic        conv_done, conv_continuous, conv_async_clk, conv_start, irq;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, r;
  logic [11:0] conv_data;
  logic [4:0]  conv_channel;
  logic [1:0]  conv_mode;
  int          failures, cmp_count;
  int          start_seen = 0;  // Start pulses seen
  // Count converter start pulses, one per edge at which the pulse stands
  always @(posedge clock) if (conv_start === 1'b1) start_seen++;
  // Ordinary cases, one per mode plus a second twelve-bit row
  arc_row_type rows [4] = '{'{2'h0, 12'hABC, 8'h00, 8'hAB}, '{2'h1, 12'hABC, 8'h0A, 8'hBC},
                            '{2'h2, 12'hABC, 8'h02, 8'hAF}, '{2'h1, 12'h5F1, 8'h05, 8'hF1}};
  arc_ctrl arc_ctrl_inst (.clock(clock), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .conv_done(conv_done), .conv_data(conv_data),
    .conv_channel(conv_channel), .conv_continuous(conv_continuous), .conv_mode(conv_mode),
    .conv_async_clk(conv_async_clk), .conv_start(conv_start), .irq(irq));
  // 100 MHz clock
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // Verdict and end of run
  task automatic complete_run;
    if (failures == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : complete_run
  // Compare one value
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask : chk
  // One APB transfer, entered just after a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 50);
    // Bounded wait for the answer
    if (n >= 50) begin
      failures++;
      $display("[FAIL] %0t no pready", $time);
      complete_run();
    end
    r = prdata;
    chk({31'h0, pslverr}, 32'h0);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask : apb
  // One completion pulse with its result
  task automatic conv(input logic [11:0] v);
    conv_done <= 1'b1;
    conv_data <= v;
    @(posedge clock);
    conv_done <= 1'b0;
  endtask : conv
  // Main sequence
  initial begin
    {rstn, psel, penable, pwrite, conv_done} = 5'h00;
    {paddr, pwdata, conv_data} = 52'h0;
    failures = 0;
    cmp_count = 0;
    repeat (5) @(posedge clock);
    rstn <= 1'b1;
    @(posedge clock);
    foreach (rows[i]) begin
      apb(1'b1, ARC_OFS_CFG, {30'h0, rows[i].mode});
      conv(rows[i].data);
      apb(1'b0, ARC_OFS_RES_HI, 32'h0);
      chk(r, {24'h0, rows[i].hi});
      apb(1'b0, ARC_OFS_RES_LO, 32'h0);
      chk(r, {24'h0, rows[i].lo});
    end
    // Conversion lands on the high-byte access edge
    conv(12'h123);
    fork
      apb(1'b0, ARC_OFS_RES_HI, 32'h0);
      begin
        @(posedge clock);
        conv(12'h456);
      end
    join
    chk(r, 32'h01);
    apb(1'b0, ARC_OFS_RES_LO, 32'h0);
    chk(r, 32'h23);
    apb(1'b0, ARC_OFS_RES_HI, 32'h0);
    chk(r, 32'h04);
    apb(1'b0, ARC_OFS_RES_LO, 32'h0);
    chk(r, 32'h56);
    // Eight-bit mode never freezes; async clock select
    apb(1'b1, ARC_OFS_CFG, 32'h4);
    chk({31'h0, conv_async_clk}, 32'h1);
    conv(12'hABC);
    apb(1'b0, ARC_OFS_RES_HI, 32'h0);
    chk(r, 32'h0);
    conv(12'hDEF);
    apb(1'b0, ARC_OFS_RES_LO, 32'h0);
    chk(r, 32'hDE);
    // Flag, clear by write, completion during write
    apb(1'b1, ARC_OFS_CTRL, 32'h1F);
    apb(1'b1, ARC_OFS_CTRL, 32'h43);
    conv(12'h321);
    apb(1'b0, ARC_OFS_CTRL, 32'h0);
    chk(r, 32'hC3);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, ARC_OFS_CTRL, 32'h43);
    apb(1'b0, ARC_OFS_CTRL, 32'h0);
    chk(r, 32'h43);
    chk({31'h0, irq}, 32'h0);
    fork
      apb(1'b1, ARC_OFS_CTRL, 32'h43);
      begin
        @(posedge clock);
        conv(12'h777);
      end
    join
    @(posedge clock);
    chk({31'h0, irq}, 32'h1);
    apb(1'b0, ARC_OFS_CTRL, 32'h0);
    chk(r, 32'hC3);
    apb(1'b0, 8'h10, 32'h0);
    chk(r, 32'h0);
    apb(1'b1, 8'h10, 32'hFFFFFFFF);
    apb(1'b1, ARC_OFS_CTRL, 32'h3F);
    chk({31'h0, conv_continuous}, 32'h1);
    chk(start_seen, 32'h3);
    apb(1'b0, ARC_OFS_CFG, 32'h0);
    chk(r, 32'h4);
    // Second reset in mid-run
    rstn <= 1'b0;
    repeat (2) @(posedge clock);
    chk({27'h0, conv_channel}, 32'h1F);
    chk({29'h0, conv_async_clk, conv_mode}, 32'h0);
    rstn <= 1'b1;
    @(posedge clock);
    apb(1'b0, ARC_OFS_CTRL, 32'h0);
    chk(r, 32'h1F);
    complete_run();
  end
endmodule : testbench
